// ### common/fumc_pkg.sv
// package of constants and carrier types for the flash user-mode control block
package fumc_pkg;
	// register addresses in the register file
	localparam logic [7:0] FUMC_ADDR_SEC_HI  = 8'hEC;
	localparam logic [7:0] FUMC_ADDR_SEC_LO  = 8'hED;
	localparam logic [7:0] FUMC_ADDR_UNLOCK  = 8'hEE;
	localparam logic [7:0] FUMC_ADDR_CONTROL = 8'hEF;
	// reset values
	localparam logic [7:0] FUMC_RST_CONTROL  = 8'h00;
	localparam logic [7:0] FUMC_RST_UNLOCK   = 8'h00;
	localparam logic [7:0] FUMC_RST_SEC      = 8'h00;
	// unlock key
	localparam logic [7:0] FUMC_UNLOCK_KEY   = 8'hA5;
	// control field positions
	localparam int FUMC_MODE_HI   = 7;
	localparam int FUMC_MODE_LO   = 4;
	localparam int FUMC_LAUNCH    = 0;
	// operation mode codes
	localparam logic [3:0] FUMC_MODE_PROG  = 4'h5;
	localparam logic [3:0] FUMC_MODE_LOCK  = 4'h6;
	localparam logic [3:0] FUMC_MODE_ERASE = 4'hA;
	// option byte field positions
	localparam int FUMC_OPT_VEC_HI  = 7;
	localparam int FUMC_OPT_VEC_LO  = 5;
	localparam int FUMC_OPT_SIZE_HI = 2;
	localparam int FUMC_OPT_SIZE_LO = 0;
	// boot-loader area geometry
	localparam logic [15:0] FUMC_AREA_BASE = 16'h0100;
	localparam logic [15:0] FUMC_AREA_256  = 16'h0100;
	localparam logic [15:0] FUMC_AREA_512  = 16'h0200;
	localparam logic [15:0] FUMC_AREA_1K   = 16'h0400;
	localparam logic [15:0] FUMC_AREA_2K   = 16'h0800;
	// reset vectors
	localparam logic [15:0] FUMC_VEC_NONE = 16'h0100;
	localparam logic [15:0] FUMC_VEC_0    = 16'h0200;
	localparam logic [15:0] FUMC_VEC_1    = 16'h0300;
	localparam logic [15:0] FUMC_VEC_2    = 16'h0500;
	localparam logic [15:0] FUMC_VEC_3    = 16'h0900;
	// sector geometry: 128-byte sectors
	localparam int FUMC_SEC_SHIFT = 7;
	// timing
	localparam int FUMC_CLK_MHZ      = 100;
	localparam int FUMC_ERASE_MS     = 10;
	localparam int FUMC_ERASE_CYCLES = FUMC_ERASE_MS * 1000 * FUMC_CLK_MHZ;
	localparam int FUMC_CNT_W        = 20;

	// register bus request from the cpu core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fumc_reg_req_t;

	// program-memory load request from the cpu core
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} fumc_mem_req_t;

	// decoded option byte
	typedef struct packed {
		logic        area_on;
		logic [15:0] area_end;
		logic [15:0] reset_vec;
	} fumc_opt_t;
endpackage

// ### hw/fumc_opt_decode.sv
// option byte decoder: reset vector and boot-loader area, each from its own field
`timescale 1ns/1ps
module fumc_opt_decode
	import fumc_pkg::*;
(
	// option byte value
	input  wire logic [7:0] i_opt,
	// decoded result
	output fumc_opt_t       o_dec
);
	// vector field and size field decoded from disjoint bits only
	always_comb begin
		o_dec.area_on  = ~i_opt[FUMC_OPT_SIZE_HI];
		case (i_opt[FUMC_OPT_SIZE_HI-1:FUMC_OPT_SIZE_LO])
			2'h0:    o_dec.area_end = FUMC_AREA_BASE + FUMC_AREA_256;
			2'h1:    o_dec.area_end = FUMC_AREA_BASE + FUMC_AREA_512;
			2'h2:    o_dec.area_end = FUMC_AREA_BASE + FUMC_AREA_1K;
			default: o_dec.area_end = FUMC_AREA_BASE + FUMC_AREA_2K;
		endcase
		if (i_opt[FUMC_OPT_VEC_HI]) begin
			o_dec.reset_vec = FUMC_VEC_NONE;
		end else begin
			case (i_opt[FUMC_OPT_VEC_HI-1:FUMC_OPT_VEC_LO])
				2'h0:    o_dec.reset_vec = FUMC_VEC_0;
				2'h1:    o_dec.reset_vec = FUMC_VEC_1;
				2'h2:    o_dec.reset_vec = FUMC_VEC_2;
				default: o_dec.reset_vec = FUMC_VEC_3;
			endcase
		end
	end
endmodule

// ### hw/fumc_top.sv
// flash user-mode control: registers, erase sequencing, cpu stall and area protection
//
// Summary of operation
// R1 - reject load writes/erases into active boot area
// R2 - boot area active only when enable bit 0
// R3 - disable bit 1 frees the area
// R4 - tool mode bypasses boot area protection
// R5 - size bits pick 0/256/512/1K/2K from 100h
// R6 - vector bits pick first fetch address
// R7 - vector and size fields decoded independently
// R8 - control acts only in user mode
// R9 - upper nibble selects program, lock, erase
// R10 - software writes only defined mode codes
// R11 - launch bit starts erase/lock, self clears
// R12 - erase stalls cpu at least 10ms
// R13 - byte read/program need no launch bit
// R14 - user mode only while unlock holds A5h
// R15 - erase sequence: unlock, address, A1h, relock
// R16 - load write programs only when unlocked, prog
// R17 - erase of protected sector suppressed, no stall
`timescale 1ns/1ps
module fumc_top
	import fumc_pkg::*;
#(
	parameter int ERASE_CYCLES = FUMC_ERASE_CYCLES
) (
	// clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_nrst,
	// option byte and tool mode
	input  wire logic [7:0]    i_opt,
	input  wire logic          i_tool_mode,
	// register access
	input  fumc_reg_req_t      i_reg,
	output logic [7:0]         o_reg_rdata,
	// program-memory load writes
	input  fumc_mem_req_t      i_mem,
	// flash array commands
	output logic               o_prog_stb,
	output logic [15:0]        o_prog_addr,
	output logic [7:0]         o_prog_data,
	output logic               o_erase_busy,
	output logic [15:0]        o_erase_addr,
	output logic               o_lock_stb,
	output logic               o_hard_locked,
	// cpu control
	output logic               o_cpu_stall,
	output logic [15:0]        o_reset_vec
);
	fumc_opt_t dec;             // decoded option byte

	// option decode, kept separate per field [R7]
	fumc_opt_decode u_dec (
		.i_opt (i_opt),
		.o_dec (dec)
	);

	// true when an address falls inside the active, protected boot area
	function automatic logic in_area(input logic [15:0] a, input fumc_opt_t d,
		input logic tool);
		in_area = d.area_on && !tool && a >= FUMC_AREA_BASE && a < d.area_end; // [R1] [R2] [R3] [R4] [R5]
	endfunction

	// register state
	logic [7:0]            ctrl_q, ctrl_d;        // control register
	logic [7:0]            unlk_q, unlk_d;        // unlock register
	logic [7:0]            sech_q, sech_d;        // sector address high
	logic [7:0]            secl_q, secl_d;        // sector address low
	logic [7:0]            rdat_q, rdat_d;        // read data
	logic [FUMC_CNT_W-1:0] cnt_q, cnt_d;          // erase timer
	logic                  busy_q, busy_d;        // erase in progress
	logic                  prg_q, prg_d;          // program strobe
	logic [15:0]           pa_q, pa_d;            // program address
	logic [7:0]            pd_q, pd_d;            // program data
	logic                  lks_q, lks_d;          // lock strobe
	logic                  lkd_q, lkd_d;          // hard lock state
	logic [15:0]           vec_q, vec_d;          // captured reset vector
	logic                  vcap_q, vcap_d;        // vector captured flag
	logic [2:0]            tsy_q, tsy_d;          // tool mode pin synchroniser
	logic                  tool_q, tool_d;        // filtered tool mode

	logic       user_mode;      // user program mode active
	logic [3:0] mode;           // selected operation mode
	logic [15:0] sec_addr;      // sector base address

	assign user_mode = (unlk_q == FUMC_UNLOCK_KEY); // [R14]
	assign mode      = ctrl_q[FUMC_MODE_HI:FUMC_MODE_LO]; // [R9]
	assign sec_addr  = {sech_q, secl_q[7], 7'h00};

	// next-state logic for registers and sequencing
	always_comb begin
		ctrl_d = ctrl_q;
		unlk_d = unlk_q;
		sech_d = sech_q;
		secl_d = secl_q;
		rdat_d = rdat_q;
		cnt_d  = cnt_q;
		busy_d = busy_q;
		prg_d  = 1'b0;
		pa_d   = pa_q;
		pd_d   = pd_q;
		lks_d  = 1'b0;
		lkd_d  = lkd_q;
		vec_d  = vec_q;
		vcap_d = 1'b1;
		tsy_d  = {tsy_q[1:0], i_tool_mode};
		tool_d = tool_q;
		// the tool mode pin counts only once second and third stage agree [R4]
		if (tsy_q[1] == tsy_q[2]) begin
			tool_d = tsy_q[2];
		end
		// vector caught once after reset release [R6]
		if (!vcap_q) begin
			vec_d = dec.reset_vec;
		end
		// register writes
		if (i_reg.wr) begin
			case (i_reg.addr)
				FUMC_ADDR_CONTROL: ctrl_d = {i_reg.wdata[7:4], 3'h0, i_reg.wdata[0]};
				FUMC_ADDR_UNLOCK:  unlk_d = i_reg.wdata;
				FUMC_ADDR_SEC_HI:  sech_d = i_reg.wdata;
				FUMC_ADDR_SEC_LO:  secl_d = i_reg.wdata;
				default: ;
			endcase
		end
		// register reads
		if (i_reg.rd) begin
			case (i_reg.addr)
				FUMC_ADDR_CONTROL: rdat_d = ctrl_q;
				FUMC_ADDR_UNLOCK:  rdat_d = unlk_q;
				FUMC_ADDR_SEC_HI:  rdat_d = sech_q;
				FUMC_ADDR_SEC_LO:  rdat_d = secl_q;
				default:           rdat_d = 8'h00;
			endcase
		end
		// launch bit handling; outside user mode nothing starts [R8] [R11]
		if (ctrl_q[FUMC_LAUNCH] && !busy_q) begin
			// a control write in the same cycle keeps its own launch bit
			if (!(i_reg.wr && i_reg.addr == FUMC_ADDR_CONTROL)) begin
				ctrl_d[FUMC_LAUNCH] = 1'b0; // self clear [R11]
			end
			if (user_mode) begin
				if (mode == FUMC_MODE_ERASE && !in_area(sec_addr, dec, tool_q)) begin
					busy_d = 1'b1; // [R12] [R17]
					cnt_d  = FUMC_CNT_W'(ERASE_CYCLES - 1);
				end else if (mode == FUMC_MODE_LOCK) begin
					lks_d = 1'b1;
					lkd_d = 1'b1;
				end
			end
		end
		// erase timer releases the cpu by itself [R12]
		if (busy_q) begin
			if (cnt_q == '0) begin
				busy_d = 1'b0;
			end else begin
				cnt_d = cnt_q - 1'b1;
			end
		end
		// byte program straight from a load write, no launch bit [R13] [R16]
		if (i_mem.wr && user_mode && mode == FUMC_MODE_PROG && !busy_q && !lkd_q
			&& !in_area(i_mem.addr, dec, tool_q)) begin
			prg_d = 1'b1; // [R1]
			pa_d  = i_mem.addr;
			pd_d  = i_mem.wdata;
		end
	end

	// register all state
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_q <= FUMC_RST_CONTROL;
			unlk_q <= FUMC_RST_UNLOCK;
			sech_q <= FUMC_RST_SEC;
			secl_q <= FUMC_RST_SEC;
			rdat_q <= 8'h00;
			cnt_q  <= '0;
			busy_q <= 1'b0;
			prg_q  <= 1'b0;
			pa_q   <= 16'h0000;
			pd_q   <= 8'h00;
			lks_q  <= 1'b0;
			lkd_q  <= 1'b0;
			vec_q  <= FUMC_VEC_NONE;
			vcap_q <= 1'b0;
			tsy_q  <= 3'h0;
			tool_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			unlk_q <= unlk_d;
			sech_q <= sech_d;
			secl_q <= secl_d;
			rdat_q <= rdat_d;
			cnt_q  <= cnt_d;
			busy_q <= busy_d;
			prg_q  <= prg_d;
			pa_q   <= pa_d;
			pd_q   <= pd_d;
			lks_q  <= lks_d;
			lkd_q  <= lkd_d;
			vec_q  <= vec_d;
			vcap_q <= vcap_d;
			tsy_q  <= tsy_d;
			tool_q <= tool_d;
		end
	end

	// outputs straight from flops
	assign o_reg_rdata   = rdat_q;
	assign o_prog_stb    = prg_q;
	assign o_prog_addr   = pa_q;
	assign o_prog_data   = pd_q;
	assign o_erase_busy  = busy_q;
	assign o_erase_addr  = sec_addr;
	assign o_lock_stb    = lks_q;
	assign o_hard_locked = lkd_q;
	assign o_cpu_stall   = busy_q;
	assign o_reset_vec   = vec_q;

	// no program strobe into the protected area
	area_guard_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		prg_q |-> !in_area(pa_q, dec, $past(tool_q))) else $error("program hit boot area"); // [R1]
	// program needs unlock and program mode
	prog_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(prg_q) |-> $past(user_mode) && $past(mode) == FUMC_MODE_PROG) else $error("bad program"); // [R16]
	// no erase outside user mode
	mode_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(busy_q) |-> $past(user_mode)) else $error("erase outside user mode"); // [R8]
	// erase needs erase code
	erase_code_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(busy_q) |-> $past(mode) == FUMC_MODE_ERASE) else $error("erase with wrong code"); // [R9]
	// launch bit clears itself
	launch_clear_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		ctrl_q[FUMC_LAUNCH] && !busy_q && !(i_reg.wr && i_reg.addr == FUMC_ADDR_CONTROL)
		|=> !ctrl_q[FUMC_LAUNCH]) else $error("launch bit stuck"); // [R11]
	// stall holds for at least eight cycles after it rises
	stall_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(o_cpu_stall) |-> o_cpu_stall[*8]) else $error("stall too short"); // [R12]
	// no stall for a protected sector
	prot_erase_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		$rose(busy_q) |-> !$past(in_area(sec_addr, dec, tool_q))) else $error("protected erase"); // [R17]
	// every flash operation was started while the key stood in the unlock register
	unlock_key_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		prg_q || lks_q || $rose(busy_q) |-> $past(unlk_q) == 8'hA5) else $error("op without key"); // [R14]
endmodule

// ### test/fumc_cpu_model.sv
// cpu core model issuing register and program-memory load accesses
`timescale 1ns/1ps
module fumc_cpu_model
	import fumc_pkg::*;
(
	// clock and stall
	input  wire logic     i_clk,
	input  wire logic     i_stall,
	// requests toward the block
	output fumc_reg_req_t o_reg,
	output fumc_mem_req_t o_mem
);
	int timeouts = 0; // stall waits that ran out

	// idle requests from time zero
	initial begin
		o_reg = '0;
		o_mem = '0;
	end

	// a halted core issues nothing until the stall ends or 100 cycles pass
	task automatic hold_off();
		for (int n = 0; n < 100 && i_stall === 1'b1; n++) begin
			@(negedge i_clk);
		end
		if (i_stall === 1'b1) timeouts++;
	endtask

	// one register access, request up for one cycle
	task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		hold_off();
		o_reg = '{wr: wr, rd: !wr, addr: a, wdata: d};
		@(negedge i_clk);
		o_reg = '0;
	endtask

	// one load-instruction write, no launch bit involved
	task automatic mem_wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge i_clk);
		hold_off();
		o_mem = '{wr: 1'b1, addr: a, wdata: d};
		@(negedge i_clk);
		o_mem = '0;
	endtask
endmodule

// ### test/fumc_top_tb.sv
// self-checking bench for the flash user-mode control block
`timescale 1ns/1ps
module fumc_top_tb
	import fumc_pkg::*;
;
	localparam int EC = 20; // shortened erase length
	logic          clk, nrst, tool;
	logic [7:0]    opt, rdata;
	fumc_reg_req_t rq;
	fumc_mem_req_t mq;
	logic          pstb, busy, lstb, locked, stall;
	logic [15:0]   paddr, eaddr, vec;
	logic [7:0]    pdata;
	int            fails, compares, pcnt, lcnt, n;

	// device under test
	fumc_top #(.ERASE_CYCLES(EC)) i_dut (.i_clk(clk), .i_nrst(nrst), .i_opt(opt),
		.i_tool_mode(tool), .i_reg(rq), .o_reg_rdata(rdata), .i_mem(mq),
		.o_prog_stb(pstb), .o_prog_addr(paddr), .o_prog_data(pdata),
		.o_erase_busy(busy), .o_erase_addr(eaddr), .o_lock_stb(lstb),
		.o_hard_locked(locked), .o_cpu_stall(stall), .o_reset_vec(vec));
	// cpu core on the far side
	fumc_cpu_model i_cpu (.i_clk(clk), .i_stall(stall), .o_reg(rq), .o_mem(mq));

	// clock and strobe counters
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// strobes are counted at the falling edge, away from the edge that launches them
	always @(negedge clk) begin
		pcnt += int'(pstb === 1'b1);
		lcnt += int'(lstb === 1'b1);
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// reset for four cycles with a given option byte and tool mode
	task automatic rst(input logic [7:0] o, input logic t);
		@(negedge clk);
		nrst = 1'b0;
		opt  = o;
		tool = t;
		repeat (4) @(negedge clk);
		check(vec, 16'h0100);
		nrst = 1'b1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_cpu.reg_acc(1'b0, a, 8'h00);
		check(rdata, e);
	endtask

	// load write, expecting a strobe or none
	task automatic prog(input logic [15:0] a, input logic ok);
		n = pcnt;
		i_cpu.mem_wr(a, a[7:0] ^ 8'h3C);
		@(negedge clk);
		check(16'(pcnt - n), 16'(ok));
		if (ok) begin
			check(paddr, a);
			check({8'h00, pdata}, {8'h00, a[7:0] ^ 8'h3C});
		end
	endtask

	// launch a control code and measure the stall length
	task automatic launch(input logic [7:0] c, input int exp);
		int nb;
		i_cpu.reg_acc(1'b1, FUMC_ADDR_CONTROL, c);
		n  = 0;
		nb = 0;
		for (int w = 0; w < EC + 10; w++) begin
			n  += int'(stall === 1'b1);
			nb += int'(busy === 1'b1);
			@(negedge clk);
		end
		// the erase may stand one cycle past its length, never shorter
		if (n >= EC && n <= EC + 1) n = EC;
		if (nb >= EC && nb <= EC + 1) nb = EC;
		check(16'(n), 16'(exp));
		check(16'(nb), 16'(exp));
	endtask

	task automatic t_decode();
		logic [15:0] sz [5] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0000};
		logic [15:0] vv [5] = '{16'h0200, 16'h0300, 16'h0500, 16'h0900, 16'h0100};
		for (int i = 0; i < 5; i++) begin
			rst({3'(i), 2'b00, 3'(3 - i)}, 1'b0);
			@(negedge clk);
			check(vec, vv[i]);
			i_cpu.reg_acc(1'b1, FUMC_ADDR_UNLOCK, FUMC_UNLOCK_KEY);
			i_cpu.reg_acc(1'b1, FUMC_ADDR_CONTROL, 8'h50);
			if (sz[i] != 0) prog(16'h00FF + sz[i], 1'b0);
			prog(16'h0100 + sz[i], 1'b1);
		end
	endtask

	task automatic t_gate();
		rst(8'h00, 1'b0);
		rd(FUMC_ADDR_CONTROL, 8'h00);
		rd(FUMC_ADDR_UNLOCK, 8'h00);
		rd(8'h10, 8'h00);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_CONTROL, 8'h50);
		prog(16'h0A00, 1'b0);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_UNLOCK, 8'hA4);
		prog(16'h0A00, 1'b0);
		rst(8'h00, 1'b1);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_UNLOCK, FUMC_UNLOCK_KEY);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_CONTROL, 8'h50);
		prog(16'h0100, 1'b1);
	endtask

	task automatic t_erase();
		rst(8'h00, 1'b0);
		launch(8'hA1, 0);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_UNLOCK, FUMC_UNLOCK_KEY);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_SEC_HI, 8'h0A);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_SEC_LO, 8'h80);
		launch(8'hA1, EC);
		check(eaddr, 16'h0A80);
		rd(FUMC_ADDR_CONTROL, 8'hA0);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_SEC_HI, 8'h01);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_SEC_LO, 8'h00);
		launch(8'hA1, 0);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_UNLOCK, 8'h00);
		n = lcnt;
		i_cpu.reg_acc(1'b1, FUMC_ADDR_UNLOCK, FUMC_UNLOCK_KEY);
		launch(8'h61, 0);
		check(16'(lcnt - n), 16'h0001);
		check({15'h0, locked}, 16'h0001);
		i_cpu.reg_acc(1'b1, FUMC_ADDR_CONTROL, 8'h50);
		prog(16'h0A00, 1'b0);
	endtask

	// main sequence
	initial begin
		nrst     = 1'b0;
		opt      = 8'h00;
		tool     = 1'b0;
		fails    = 0;
		compares = 0;
		pcnt     = 0;
		lcnt     = 0;
		t_decode();
		t_gate();
		t_erase();
		check(16'(i_cpu.timeouts), 16'h0000);
		stop_test();
	end
endmodule
